// ### src/aux_output_interlock.sv
// Interlocked auxiliary power output controller with a classic Wishbone register slave.
`timescale 1ns/100ps
`default_nettype none
module aux_output_interlock (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Operator and key.
  input  wire logic        switch_on_in,
  input  wire logic        ignition_key_position_in,
  // Vehicle sensor states.
  input  wire logic        park_brake_in,
  input  wire logic        door_open_in,
  input  wire logic        power_takeoff_in,
  input  wire logic        engine_running_in,
  input  wire logic [7:0]  vehicle_speed_in,
  input  wire logic [7:0]  trans_gear_in,
  // Measured output current and system load-shed level.
  input  wire logic [7:0]  output_current_in,
  input  wire logic [1:0]  shed_level_in,
  // Drive to the remote power output module.
  output logic             aux_power_output_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    aux_interlock_pkg::config_t cfg;
    logic                       switch_prev;
    logic                       latched_off;
    logic                       fuse_tripped;
    logic                       shed_active;
    logic                       output_on;
    logic                       ack;
    logic [31:0]                rdata;
  } top_state_t;

  top_state_t                 state_r;
  top_state_t                 state_nxt;

  aux_interlock_pkg::sensor_t sensor_raw;
  aux_interlock_pkg::sensor_t sensor_sync;
  aux_interlock_pkg::demand_t demand_raw;
  aux_interlock_pkg::demand_t demand_sync;
  logic                       cond_ok;

  logic                       bus_req;
  logic                       bus_wr;
  logic                       bus_rd;
  logic [31:0]                wmask;
  logic [31:0]                cfg_word;
  logic [31:0]                thr_word;
  logic [31:0]                status_word;
  logic [31:0]                cfg_new;
  logic [31:0]                thr_new;
  logic                       ctl_fuse_clr;
  logic                       ctl_latch_clr;
  logic                       switch_rise;
  logic                       switch_fall;
  logic                       over_current;
  logic                       shed_now;
  logic                       demand_ok;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_comb
  begin
    sensor_raw                = '0;
    sensor_raw.park_brake     = park_brake_in;
    sensor_raw.door_open      = door_open_in;
    sensor_raw.power_takeoff  = power_takeoff_in;
    sensor_raw.engine_running = engine_running_in;
    sensor_raw.speed          = vehicle_speed_in;
    sensor_raw.gear           = trans_gear_in;
    demand_raw                = '0;
    demand_raw.switch_on      = switch_on_in;
    demand_raw.key_on         = ignition_key_position_in;
    demand_raw.current        = output_current_in;
    demand_raw.shed_level     = shed_level_in;
  end

  aux_sync #(
    .WIDTH ($bits(aux_interlock_pkg::sensor_t))
  ) u_sensor_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (sensor_raw),
    .sync_out  (sensor_sync)
  );

  aux_sync #(
    .WIDTH ($bits(aux_interlock_pkg::demand_t))
  ) u_demand_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (demand_raw),
    .sync_out  (demand_sync)
  );

  // ****************************************************************
  // Interlock condition
  // ****************************************************************
  aux_interlock_eval u_eval (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .sensor_in   (sensor_sync),
    .cfg_in      (state_r.cfg),
    .cond_ok_out (cond_ok)
  );

  // ****************************************************************
  // Register views
  // ****************************************************************
  always_comb
  begin
    wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

    cfg_word = '0;
    cfg_word[aux_interlock_pkg::SEL_LSB +: aux_interlock_pkg::SEL_W] = state_r.cfg.selector;
    cfg_word[aux_interlock_pkg::LATCH_BIT] = state_r.cfg.latch_after_interlock;
    cfg_word[aux_interlock_pkg::SHED_LSB +: aux_interlock_pkg::SHED_W] =
      state_r.cfg.shed_priority_level;

    thr_word = '0;
    thr_word[aux_interlock_pkg::SPEED_LSB +: aux_interlock_pkg::BYTE_W] =
      state_r.cfg.speed_threshold;
    thr_word[aux_interlock_pkg::GEAR_LSB +: aux_interlock_pkg::BYTE_W] =
      state_r.cfg.gear_threshold;
    thr_word[aux_interlock_pkg::FUSE_LSB +: aux_interlock_pkg::BYTE_W] =
      state_r.cfg.fuse_current_limit;

    status_word      = '0;
    status_word[0]   = state_r.output_on;
    status_word[1]   = cond_ok;
    status_word[2]   = state_r.latched_off;
    status_word[3]   = state_r.fuse_tripped;
    status_word[4]   = state_r.shed_active;
    status_word[5]   = demand_sync.key_on;
    status_word[6]   = demand_sync.switch_on;

    cfg_new = (cfg_word & ~wmask) | (wb_dat_in & wmask);
    thr_new = (thr_word & ~wmask) | (wb_dat_in & wmask);
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  always_comb
  begin
    bus_req       = wb_cyc_in && wb_stb_in && !state_r.ack;
    bus_wr        = bus_req && wb_we_in;
    bus_rd        = bus_req && !wb_we_in;
    ctl_fuse_clr  = bus_wr && (wb_adr_in == aux_interlock_pkg::ADDR_CONTROL) &&
                    wb_sel_in[0] && wb_dat_in[aux_interlock_pkg::FUSE_CLR_BIT];
    ctl_latch_clr = bus_wr && (wb_adr_in == aux_interlock_pkg::ADDR_CONTROL) &&
                    wb_sel_in[0] && wb_dat_in[aux_interlock_pkg::LATCH_CLR_BIT];
  end

  // ****************************************************************
  // Output decision
  // ****************************************************************
  always_comb
  begin
    switch_rise  = demand_sync.switch_on && !state_r.switch_prev;
    switch_fall  = !demand_sync.switch_on && state_r.switch_prev;
    over_current = state_r.output_on &&
                   (demand_sync.current > state_r.cfg.fuse_current_limit);
    shed_now     = (state_r.cfg.shed_priority_level != aux_interlock_pkg::SHED_NONE) &&
                   (demand_sync.shed_level != aux_interlock_pkg::SHED_NONE) &&
                   (state_r.cfg.shed_priority_level <= demand_sync.shed_level);
    demand_ok    = demand_sync.switch_on && demand_sync.key_on;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    state_nxt             = state_r;
    state_nxt.switch_prev = demand_sync.switch_on;
    state_nxt.shed_active = shed_now;

    // Latched drop-out: set when the condition fails under a live request.
    if (state_r.cfg.latch_after_interlock && demand_ok && !cond_ok)
    begin
      state_nxt.latched_off = 1'b1;
    end
    else if (switch_fall || switch_rise || ctl_latch_clr ||
             !state_r.cfg.latch_after_interlock)
    begin
      state_nxt.latched_off = 1'b0;
    end

    // Fuse trip: set wins over any clear in the same cycle.
    if (over_current)
    begin
      state_nxt.fuse_tripped = 1'b1;
    end
    else if (switch_fall || ctl_fuse_clr)
    begin
      state_nxt.fuse_tripped = 1'b0;
    end

    // Output updates one tick after the inputs that steer it.
    state_nxt.output_on = demand_ok && cond_ok && !state_r.latched_off &&
                          !(state_r.cfg.latch_after_interlock && !cond_ok) &&
                          !state_r.fuse_tripped && !over_current &&
                          !shed_now;

    // Bus answer in the cycle after the request.
    state_nxt.ack   = bus_req;
    state_nxt.rdata = '0;
    if (bus_rd)
    begin
      case (wb_adr_in)
        aux_interlock_pkg::ADDR_CONFIG:    state_nxt.rdata = cfg_word;
        aux_interlock_pkg::ADDR_THRESHOLD: state_nxt.rdata = thr_word;
        aux_interlock_pkg::ADDR_STATUS:    state_nxt.rdata = status_word;
        default:                           state_nxt.rdata = '0;
      endcase
    end

    if (bus_wr)
    begin
      case (wb_adr_in)
        aux_interlock_pkg::ADDR_CONFIG:
        begin
          state_nxt.cfg.selector =
            cfg_new[aux_interlock_pkg::SEL_LSB +: aux_interlock_pkg::SEL_W];
          state_nxt.cfg.latch_after_interlock = cfg_new[aux_interlock_pkg::LATCH_BIT];
          state_nxt.cfg.shed_priority_level =
            cfg_new[aux_interlock_pkg::SHED_LSB +: aux_interlock_pkg::SHED_W];
        end
        aux_interlock_pkg::ADDR_THRESHOLD:
        begin
          state_nxt.cfg.speed_threshold =
            thr_new[aux_interlock_pkg::SPEED_LSB +: aux_interlock_pkg::BYTE_W];
          state_nxt.cfg.gear_threshold =
            thr_new[aux_interlock_pkg::GEAR_LSB +: aux_interlock_pkg::BYTE_W];
          state_nxt.cfg.fuse_current_limit =
            thr_new[aux_interlock_pkg::FUSE_LSB +: aux_interlock_pkg::BYTE_W];
        end
        default:
        begin
          state_nxt.cfg = state_r.cfg;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r                           <= '0;
      state_r.cfg.selector              <= aux_interlock_pkg::SELECTOR_RST;
      state_r.cfg.latch_after_interlock <= aux_interlock_pkg::LATCH_RST;
      state_r.cfg.shed_priority_level   <= aux_interlock_pkg::SHED_PRIO_RST;
      state_r.cfg.speed_threshold       <= aux_interlock_pkg::SPEED_RST;
      state_r.cfg.gear_threshold        <= aux_interlock_pkg::GEAR_RST;
      state_r.cfg.fuse_current_limit    <= aux_interlock_pkg::FUSE_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign wb_dat_out           = state_r.rdata;
  assign wb_ack_out           = state_r.ack;
  assign aux_power_output_out = state_r.output_on;

endmodule : aux_output_interlock
`default_nettype wire

// ### src/aux_interlock_pkg.sv
// Shared constants, register map and carrier types of the auxiliary output interlock.
// How it works
// - Latch off: output returns when condition returns.
// - Latch on: interlock drop keeps output off.
// - Speed threshold used only for selectors 9, 10.
// - Gear threshold used only for selectors 13, 14.
// - Gear code: neutral 125, forward up, reverse down.
// - Current above fuse limit switches output off.
// - Selector 0: no sensor condition applies.
// - Selectors 1, 2: park brake set, released.
// - Selectors 3, 4: door open, all closed.
// - Selectors 5, 6: power takeoff engaged, disengaged.
// - Selectors 7, 8: engine running, stopped.
// - Selectors 9, 10: speed above, below threshold.
// - Selectors 11, 12: vehicle stationary, moving.
// - Selectors 13, 14: gear above, below threshold.
// - Selectors 15, 16: neutral, out of neutral.
// - Shed level 0 exempt; 1 first, 3 last.
// - Latched drop-out clears by switch off then on.
// - Output only with key in ignition or accessory.
// - Default setup drops output at 30 mph.
package aux_interlock_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CONFIG    = 8'h00;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_CONTROL   = 8'h0c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SEL_LSB      = 0;
  localparam int SEL_W        = 5;
  localparam int LATCH_BIT    = 8;
  localparam int SHED_LSB     = 16;
  localparam int SHED_W       = 2;
  localparam int SPEED_LSB    = 0;
  localparam int GEAR_LSB     = 8;
  localparam int FUSE_LSB     = 16;
  localparam int BYTE_W       = 8;
  localparam int FUSE_CLR_BIT = 0;
  localparam int LATCH_CLR_BIT = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [4:0] SELECTOR_RST  = 5'h0a;
  localparam logic       LATCH_RST     = 1'b0;
  localparam logic [1:0] SHED_PRIO_RST = 2'h1;
  localparam logic [7:0] SPEED_RST     = 8'h1e;
  localparam logic [7:0] GEAR_RST      = 8'h7d;
  localparam logic [7:0] FUSE_RST      = 8'hc8;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [7:0] GEAR_NEUTRAL = 8'h7d;
  localparam logic [7:0] SPEED_STOPPED = 8'h00;
  localparam logic [1:0] SHED_NONE    = 2'h0;

  localparam logic [4:0] SEL_NONE        = 5'h00;
  localparam logic [4:0] SEL_BRAKE_SET   = 5'h01;
  localparam logic [4:0] SEL_BRAKE_OFF   = 5'h02;
  localparam logic [4:0] SEL_DOOR_OPEN   = 5'h03;
  localparam logic [4:0] SEL_DOOR_SHUT   = 5'h04;
  localparam logic [4:0] SEL_PTO_ON      = 5'h05;
  localparam logic [4:0] SEL_PTO_OFF     = 5'h06;
  localparam logic [4:0] SEL_ENG_RUN     = 5'h07;
  localparam logic [4:0] SEL_ENG_STOP    = 5'h08;
  localparam logic [4:0] SEL_SPEED_ABOVE = 5'h09;
  localparam logic [4:0] SEL_SPEED_BELOW = 5'h0a;
  localparam logic [4:0] SEL_STOPPED     = 5'h0b;
  localparam logic [4:0] SEL_MOVING      = 5'h0c;
  localparam logic [4:0] SEL_GEAR_ABOVE  = 5'h0d;
  localparam logic [4:0] SEL_GEAR_BELOW  = 5'h0e;
  localparam logic [4:0] SEL_NEUTRAL     = 5'h0f;
  localparam logic [4:0] SEL_IN_GEAR     = 5'h10;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic       park_brake;
    logic       door_open;
    logic       power_takeoff;
    logic       engine_running;
    logic [7:0] speed;
    logic [7:0] gear;
  } sensor_t;

  typedef struct packed {
    logic       switch_on;
    logic       key_on;
    logic [7:0] current;
    logic [1:0] shed_level;
  } demand_t;

  typedef struct packed {
    logic [4:0] selector;
    logic       latch_after_interlock;
    logic [1:0] shed_priority_level;
    logic [7:0] speed_threshold;
    logic [7:0] gear_threshold;
    logic [7:0] fuse_current_limit;
  } config_t;

endpackage : aux_interlock_pkg

// ### src/aux_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/100ps
`default_nettype none
module aux_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  // The first stage feeds only the second stage.
  always_comb
  begin
    state_nxt        = state_r;
    state_nxt.meta   = async_in;
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stable;

endmodule : aux_sync
`default_nettype wire

// ### src/aux_interlock_eval.sv
// Interlock condition selected by the configuration, evaluated from sensor states.
`timescale 1ns/100ps
`default_nettype none
module aux_interlock_eval (
  input  wire logic                       clk_in,
  input  wire logic                       resetn_in,
  input  wire aux_interlock_pkg::sensor_t sensor_in,
  input  wire aux_interlock_pkg::config_t cfg_in,
  output logic                            cond_ok_out
);

  typedef struct packed {
    logic cond_ok;
  } eval_state_t;

  eval_state_t state_r;
  eval_state_t state_nxt;
  logic        stopped;
  logic        neutral;

  always_comb
  begin
    stopped   = (sensor_in.speed == aux_interlock_pkg::SPEED_STOPPED);
    neutral   = (sensor_in.gear == aux_interlock_pkg::GEAR_NEUTRAL);
    state_nxt = state_r;
    case (cfg_in.selector)
      aux_interlock_pkg::SEL_NONE:        state_nxt.cond_ok = 1'b1;
      aux_interlock_pkg::SEL_BRAKE_SET:   state_nxt.cond_ok = sensor_in.park_brake;
      aux_interlock_pkg::SEL_BRAKE_OFF:   state_nxt.cond_ok = !sensor_in.park_brake;
      aux_interlock_pkg::SEL_DOOR_OPEN:   state_nxt.cond_ok = sensor_in.door_open;
      aux_interlock_pkg::SEL_DOOR_SHUT:   state_nxt.cond_ok = !sensor_in.door_open;
      aux_interlock_pkg::SEL_PTO_ON:      state_nxt.cond_ok = sensor_in.power_takeoff;
      aux_interlock_pkg::SEL_PTO_OFF:     state_nxt.cond_ok = !sensor_in.power_takeoff;
      aux_interlock_pkg::SEL_ENG_RUN:     state_nxt.cond_ok = sensor_in.engine_running;
      aux_interlock_pkg::SEL_ENG_STOP:    state_nxt.cond_ok = !sensor_in.engine_running;
      aux_interlock_pkg::SEL_SPEED_ABOVE:
        state_nxt.cond_ok = (sensor_in.speed > cfg_in.speed_threshold);
      aux_interlock_pkg::SEL_SPEED_BELOW:
        state_nxt.cond_ok = (sensor_in.speed < cfg_in.speed_threshold);
      aux_interlock_pkg::SEL_STOPPED:     state_nxt.cond_ok = stopped;
      aux_interlock_pkg::SEL_MOVING:      state_nxt.cond_ok = !stopped;
      aux_interlock_pkg::SEL_GEAR_ABOVE:
        state_nxt.cond_ok = (sensor_in.gear > cfg_in.gear_threshold);
      aux_interlock_pkg::SEL_GEAR_BELOW:
        state_nxt.cond_ok = (sensor_in.gear < cfg_in.gear_threshold);
      aux_interlock_pkg::SEL_NEUTRAL:     state_nxt.cond_ok = neutral;
      aux_interlock_pkg::SEL_IN_GEAR:     state_nxt.cond_ok = !neutral;
      default:                            state_nxt.cond_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign cond_ok_out = state_r.cond_ok;

endmodule : aux_interlock_eval
`default_nettype wire

// ### dv/aux_output_interlock_sva.sv
// Port checks on the interlock controller: bus answer timing and output gating.
`timescale 1ns/100ps
`default_nettype none
module aux_output_interlock_sva (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        switch_on_in,
  input wire logic        ignition_key_position_in,
  input wire logic        aux_power_output_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_take;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_rd_ack;
    wb_ack_out && !wb_we_in;
  endsequence
  property p_ack_next; s_take |=> wb_ack_out; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_idle_zero; !wb_ack_out |-> wb_dat_out == 32'h0000_0000; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside answer");
  property p_wr_zero; wb_ack_out && wb_we_in |-> wb_dat_out == 32'h0000_0000; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data on write answer");
  property p_unmapped; s_rd_ack ##0 (wb_adr_in > 8'h0c) |-> wb_dat_out == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_rsvd;
    s_rd_ack ##0 (wb_adr_in == aux_interlock_pkg::ADDR_STATUS) |-> wb_dat_out[31:7] == '0;
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status spare bits set");
  property p_key_off; !ignition_key_position_in [*4] |=> !aux_power_output_out; endproperty
  a_key_off: assert property (p_key_off) else $error("output on with key off");
  property p_sw_off; !switch_on_in [*4] |=> !aux_power_output_out; endproperty
  a_sw_off: assert property (p_sw_off) else $error("output on with switch off");
endmodule : aux_output_interlock_sva
bind aux_output_interlock aux_output_interlock_sva u_sva (.clk_in, .resetn_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .switch_on_in,
  .ignition_key_position_in, .aux_power_output_out);
`default_nettype wire

// ### dv/vehicle_model.sv
// Far side of the controller: switch, key, sensors and the powered load.
`timescale 1ns/100ps
`default_nettype none
module vehicle_model (
  input  wire aux_interlock_pkg::sensor_t sns_in,
  input  wire aux_interlock_pkg::demand_t dem_in,
  input  wire logic                       load_on_in,
  output aux_interlock_pkg::sensor_t      sns_out,
  output logic                            switch_out,
  output logic                            key_out,
  output logic [7:0]                      current_out,
  output logic [1:0]                      shed_out
);
  assign sns_out    = sns_in;
  assign switch_out = dem_in.switch_on;
  assign key_out    = dem_in.key_on;
  assign shed_out   = dem_in.shed_level;
  // An unpowered load draws no current, so a trip cannot come from a dead output.
  assign current_out = load_on_in ? dem_in.current : 8'h00;
endmodule : vehicle_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the auxiliary output interlock controller.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                       clk_in, resetn_in, cyc, stb, we, ack, out, sw_p, key_p;
  logic [7:0]                 adr, cur_p;
  logic [1:0]                 shed_p;
  logic [31:0]                wdat, rdat;
  aux_interlock_pkg::sensor_t sns, sns_p;
  aux_interlock_pkg::demand_t dem;
  int                         n_mismatch = 0;
  int                         cmp_count = 0;
  aux_interlock_pkg::sensor_t pat[3] = '{20'hf_3282, 20'h0_0078, 20'ha_147d};
  logic [8:0]                 spd[3] = '{9'h015, 9'h03c, 9'h03b};
  logic [4:0]                 shd[7] = '{5'h0a, 5'h09, 5'h1d, 5'h1e, 5'h07, 5'h13, 5'h14};

  aux_output_interlock DUT (.clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .switch_on_in(sw_p), .ignition_key_position_in(key_p),
    .park_brake_in(sns_p.park_brake), .door_open_in(sns_p.door_open),
    .power_takeoff_in(sns_p.power_takeoff), .engine_running_in(sns_p.engine_running),
    .vehicle_speed_in(sns_p.speed), .trans_gear_in(sns_p.gear), .output_current_in(cur_p),
    .shed_level_in(shed_p), .aux_power_output_out(out));
  vehicle_model u_far (.sns_in(sns), .dem_in(dem), .load_on_in(out), .sns_out(sns_p),
    .switch_out(sw_p), .key_out(key_p), .current_out(cur_p), .shed_out(shed_p));

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    check({31'h0, ack}, 32'h0000_0001, "bus answer");
    {cyc, stb} <= 2'b00;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    check(q, e, m);
  endtask : rd

  task automatic out_is(input logic e, input string m);
    repeat (8) @(posedge clk_in);
    check({31'h0, out}, {31'h0, e}, m);
  endtask : out_is

  // Expected interlock result with speed threshold 20 and gear threshold neutral.
  function automatic logic cond(input logic [4:0] s, input aux_interlock_pkg::sensor_t v);
    logic [16:0] t;
    t = {v.gear != 8'h7d, v.gear == 8'h7d, v.gear < 8'h7d, v.gear > 8'h7d, v.speed != 8'h00,
         v.speed == 8'h00, v.speed < 8'h14, v.speed > 8'h14, !v.engine_running,
         v.engine_running, !v.power_takeoff, v.power_takeoff, !v.door_open, v.door_open,
         !v.park_brake, v.park_brake, 1'b1};
    return (s > 5'h10) ? 1'b0 : t[s];
  endfunction : cond

  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    {cyc, stb, we, adr, wdat} = '0;
    sns = '0;
    dem = '0;
    resetn_in = 1'b0;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(8'h00, 32'h0001_000a, "config reset");
    rd(8'h04, 32'h00c8_7d1e, "threshold reset");
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0000_0000, "unmapped");
    dem <= '{1'b1, 1'b1, 8'h0a, 2'h0};
    foreach (spd[i])
    begin
      sns.speed <= spd[i][8:1];
      out_is(spd[i][0], "default speed");
    end
    dem.key_on <= 1'b0;
    out_is(1'b0, "key off");
    dem.key_on <= 1'b1;
    wr(8'h04, 32'h00c8_7d14);
    for (int s = 0; s < 18; s++)
      foreach (pat[p])
      begin
        wr(8'h00, 32'h0001_0000 | s);
        sns <= pat[p];
        out_is(cond(s[4:0], pat[p]), "selector");
      end
    for (int l = 0; l < 2; l++)
    begin
      sns <= pat[0];
      wr(8'h00, 32'h0001_0007 | (l << 8));
      out_is(1'b1, "engine on");
      sns.engine_running <= 1'b0;
      out_is(1'b0, "engine off");
      sns.engine_running <= 1'b1;
      out_is(l == 0, "engine back");
      dem.switch_on <= 1'b0;
      out_is(1'b0, "switch off");
      dem.switch_on <= 1'b1;
      out_is(1'b1, "switch back");
      sns.engine_running <= 1'b0;
      out_is(1'b0, "engine off again");
      sns.engine_running <= 1'b1;
      out_is(l == 0, "engine back again");
      wr(8'h0c, 32'h0000_0002);
      out_is(1'b1, "latch cleared");
    end
    wr(8'h00, 32'h0001_0000);
    wr(8'h04, 32'h0032_7d14);
    dem.current <= 8'h3c;
    out_is(1'b0, "over limit");
    dem.current <= 8'h0a;
    out_is(1'b0, "fuse held");
    rd(8'h08, 32'h0000_006a, "status tripped");
    wr(8'h0c, 32'h0000_0001);
    out_is(1'b1, "fuse clear by control");
    dem.current <= 8'h3c;
    out_is(1'b0, "over limit again");
    dem.current <= 8'h0a;
    out_is(1'b0, "fuse held again");
    dem.switch_on <= 1'b0;
    out_is(1'b0, "switch off");
    dem.switch_on <= 1'b1;
    out_is(1'b1, "fuse cleared");
    foreach (shd[i])
    begin
      wr(8'h00, {14'h0000, shd[i][4:3], 16'h0000});
      dem.shed_level <= shd[i][2:1];
      out_is(shd[i][0], "shed");
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
